// file: common/swc_consts.svh
// constants for the stream write command interpreter
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
`define SWC_CMD_STREAM_WRITE 8'h3B
`define SWC_FEAT_URGENT 7
`define SWC_FEAT_CONT 6
`define SWC_FEAT_FLUSH 5
`define SWC_FEAT_RESUME 4
`define SWC_ERR_CRC 7
`define SWC_ERR_IDNF 4
`define SWC_ERR_ABRT 2
`define SWC_ERR_COMPLETION_TIMEOUT_FLAG 0
`define SWC_ST_BSY 7
`define SWC_ST_RDY 6
`define SWC_ST_SE 5
`define SWC_ST_ERR 0
`define SWC_TICK_US 1
`define SWC_CLK_MHZ 200
`define SWC_CYC_PER_US (`SWC_TICK_US * `SWC_CLK_MHZ)
`define SWC_MIN_LIMIT_US 16'h0010
`endif

// file: common/swc_pkg.sv
// types for the stream write command interpreter
package swc_pkg;
    typedef struct packed {
        logic [7:0] feat_cur;
        logic [7:0] feat_prev;
        logic [7:0] count_cur;
        logic [7:0] count_prev;
        logic [7:0] cmd;
    } swc_taskfile_type;
    typedef struct packed {
        logic [7:0] error_report;
        logic [7:0] ending_status;
        logic [47:0] fail_lba;
    } swc_report_type;
    typedef struct packed {
        logic [15:0] div;
        logic [31:0] remaining;
        logic expired;
    } swc_timer_state_type;
endpackage

// file: core/swc_limit_timer.sv
// completion time limit down counter in microsecond ticks
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_limit_timer
    import swc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic load,
    input wire logic stop,
    input wire logic [31:0] limit_us,
    output logic expired
);
    swc_timer_state_type st;
    swc_timer_state_type next_st;
    localparam logic [15:0] cyc_last = 16'(`SWC_CYC_PER_US - 1);

    // divider gives one tick per microsecond; zero limit means no limit
    always_comb
    begin
        next_st = st;
        if (load)
        begin
            next_st.div = 16'h0000;
            next_st.remaining = limit_us;
            next_st.expired = 1'b0;
        end
        else if (stop)
        begin
            next_st.remaining = 32'h0000_0000;
        end
        else if (st.remaining != 32'h0000_0000)
        begin
            if (st.div == cyc_last)
            begin
                next_st.div = 16'h0000;
                next_st.remaining = st.remaining - 32'h0000_0001;
                if (st.remaining == 32'h0000_0001)
                    next_st.expired = 1'b1;
            end
            else
                next_st.div = st.div + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            st <= '0;
        else
            st <= next_st;
    end

    assign expired = st.expired;
endmodule

// file: core/swc_core.sv
// stream write command decode, execution sequencing and ending report
//
// Functional notes
// - command byte 3Bh starts the stream write command.
// - sector count of zero means 65536 sectors, otherwise the count given.
// - with continuous write set, transfer and media errors do not abort.
// - continuous write with errors moves all data, then SE=1, ERR=0, IDNF set, ABRT clear.
// - continuous write with limit expiry stops, SE=1, ERR=0, timeout flag set.
// - with continuous write set, the device tries to move all requested data within the limit.
// - urgent requests must finish within the completion time limit.
// - error bit 0 is set when the completion time limit expires in the move or flush phase.
// - first unrecoverable error address read back as six bytes by HOB.
// - flush bit makes completion wait until media write of the stream is done.
// - limit is high feature byte times time unit, zero uses default, min applied.
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_core
    import swc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_write,
    input wire swc_taskfile_type taskfile,
    input wire logic [15:0] time_unit_us,
    input wire logic [7:0] default_limit,
    input wire logic hob,
    input wire logic sector_done,
    input wire logic xfer_error,
    input wire logic crc_error,
    input wire logic [47:0] sector_lba,
    input wire logic flush_done,
    output logic sector_req,
    output logic flush_req,
    output logic [2:0] stream_id,
    output logic urgent_request,
    output logic resume_error_recovery,
    output logic busy,
    output logic done_pulse,
    output logic [7:0] error_report,
    output logic [7:0] ending_status,
    output logic [7:0] lba_sector_number,
    output logic [7:0] lba_cyl_low,
    output logic [7:0] lba_cyl_high
);
    typedef enum logic [1:0] {
        swc_idle_type_s,
        swc_move_s,
        swc_flush_s,
        swc_end_s
    } swc_phase_type;

    typedef struct packed {
        swc_phase_type phase;
        logic [16:0] left;
        logic cont;
        logic urgent;
        logic flush;
        logic resume;
        logic [2:0] sid;
        logic seen_err;
        logic seen_crc;
        logic seen_xfer;
        logic have_fail;
        logic timed_out;
        logic done;
        swc_report_type rep;
    } swc_state_type;

    swc_state_type st;
    swc_state_type next_st;
    logic [31:0] limit_us;
    logic timer_load;
    logic timer_stop;
    logic expired;

    // zero count stands for the largest transfer
    function automatic logic [16:0] swc_count(input logic [15:0] c);
        swc_count = (c == 16'h0000) ? 17'h1_0000 : {1'b0, c};
    endfunction

    // limit in microseconds, with fallback to default and raised to minimum
    function automatic logic [31:0] swc_limit(input logic [7:0] f,
        input logic [7:0] d, input logic [15:0] u);
        logic [7:0] m;
        logic [31:0] t;
        m = (f != 8'h00) ? f : d;
        // widen first so the 8x16 product keeps all 24 bits
        t = {8'h00, 24'(m) * 24'(u)};
        if (m == 8'h00)
            swc_limit = 32'h0000_0000;
        else if (t < {16'h0000, `SWC_MIN_LIMIT_US})
            swc_limit = {16'h0000, `SWC_MIN_LIMIT_US};
        else
            swc_limit = t;
    endfunction

    assign limit_us = swc_limit(taskfile.feat_prev, default_limit,
        time_unit_us);
    // a write while busy is refused and must not restart the limit
    assign timer_load = cmd_write && (st.phase == swc_idle_type_s)
        && (taskfile.cmd == `SWC_CMD_STREAM_WRITE);
    assign timer_stop = (st.phase == swc_end_s);

    swc_limit_timer u_timer
    (
        .mclk(mclk),
        .rstn(rstn),
        .load(timer_load),
        .stop(timer_stop),
        .limit_us(limit_us),
        .expired(expired)
    );

    // command sequencing
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.phase)
            swc_idle_type_s:
            begin
                if (timer_load)
                begin
                    next_st.phase = swc_move_s;
                    next_st.left = swc_count({taskfile.count_prev,
                        taskfile.count_cur});
                    next_st.urgent = taskfile.feat_cur[`SWC_FEAT_URGENT];
                    next_st.cont = taskfile.feat_cur[`SWC_FEAT_CONT];
                    next_st.flush = taskfile.feat_cur[`SWC_FEAT_FLUSH];
                    next_st.resume = taskfile.feat_cur[`SWC_FEAT_RESUME];
                    next_st.sid = taskfile.feat_cur[2:0];
                    next_st.seen_err = 1'b0;
                    next_st.seen_crc = 1'b0;
                    next_st.seen_xfer = 1'b0;
                    next_st.have_fail = 1'b0;
                    next_st.timed_out = 1'b0;
                    next_st.rep.ending_status = 8'h80;
                    next_st.rep.error_report = 8'h00;
                    next_st.rep.fail_lba = 48'h0000_0000_0000;
                end
            end
            swc_move_s:
            begin
                if (expired)
                begin
                    next_st.timed_out = 1'b1;
                    next_st.phase = swc_end_s;
                end
                else if (sector_done)
                begin
                    if (xfer_error || crc_error)
                    begin
                        next_st.seen_err = 1'b1;
                        next_st.seen_crc = st.seen_crc | crc_error;
                        next_st.seen_xfer = st.seen_xfer | xfer_error;
                        if (!st.have_fail)
                        begin
                            next_st.have_fail = 1'b1;
                            next_st.rep.fail_lba = sector_lba;
                        end
                    end
                    next_st.left = st.left - 17'h0_0001;
                    // abort on error unless continuous write is on
                    if ((xfer_error || crc_error) && !st.cont)
                        next_st.phase = swc_end_s;
                    else if (st.left == 17'h0_0001)
                        next_st.phase = st.flush ? swc_flush_s : swc_end_s;
                end
            end
            swc_flush_s:
            begin
                if (expired)
                begin
                    next_st.timed_out = 1'b1;
                    next_st.phase = swc_end_s;
                end
                else if (flush_done)
                    next_st.phase = swc_end_s;
            end
            swc_end_s:
            begin
                // error bits other than the four reported stay zero
                next_st.rep.error_report = 8'h00;
                next_st.rep.error_report[`SWC_ERR_CRC] = st.seen_crc;
                // continuous write always logs a type, even for crc only
                next_st.rep.error_report[`SWC_ERR_IDNF] =
                    st.seen_xfer || (st.cont && st.seen_crc);
                next_st.rep.error_report[`SWC_ERR_ABRT] =
                    st.seen_err && !st.cont;
                next_st.rep.error_report[`SWC_ERR_COMPLETION_TIMEOUT_FLAG] = st.timed_out;
                next_st.rep.ending_status = 8'h00;
                next_st.rep.ending_status[`SWC_ST_RDY] = 1'b1;
                // continuous write reports via SE with ERR clear
                if (st.cont && (st.seen_err || st.timed_out))
                    next_st.rep.ending_status[`SWC_ST_SE] = 1'b1;
                else if (st.seen_err || st.timed_out)
                    next_st.rep.ending_status[`SWC_ST_ERR] = 1'b1;
                next_st.done = 1'b1;
                next_st.phase = swc_idle_type_s;
            end
            default:
                next_st.phase = swc_idle_type_s;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.rep.ending_status <= 8'h40;
        end
        else
            st <= next_st;
    end

    // requests to the media path are held while the phase lasts
    assign sector_req = (st.phase == swc_move_s);
    assign flush_req = (st.phase == swc_flush_s);
    assign busy = (st.phase != swc_idle_type_s);
    assign stream_id = st.sid;
    assign urgent_request = st.urgent;
    assign resume_error_recovery = st.resume;
    assign done_pulse = st.done;
    assign error_report = st.rep.error_report;
    assign ending_status = st.rep.ending_status;
    // address bytes selected by the high order byte flag
    assign lba_sector_number = hob ? st.rep.fail_lba[31:24]
        : st.rep.fail_lba[7:0];
    assign lba_cyl_low = hob ? st.rep.fail_lba[39:32]
        : st.rep.fail_lba[15:8];
    assign lba_cyl_high = hob ? st.rep.fail_lba[47:40]
        : st.rep.fail_lba[23:16];
endmodule

// file: tb/swc_core_props.sv
// assertion checker for the stream write command core
`timescale 1ns/1ps
module swc_core_props
    import swc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_write,
    input wire swc_taskfile_type taskfile,
    input wire logic sector_req,
    input wire logic busy,
    input wire logic done_pulse,
    input wire logic [7:0] error_report,
    input wire logic [7:0] ending_status
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // accepted start and the two-step finish
    sequence s_accept;
        !busy && cmd_write && taskfile.cmd == 8'h3B;
    endsequence
    sequence s_start;
        busy && sector_req && ending_status == 8'h80;
    endsequence
    sequence s_finish;
        done_pulse && !ending_status[7] ##1 !done_pulse;
    endsequence
    cmd_start_a: assert property (s_accept |=> s_start)
        else $error("accepted command did not start");
    ignore_code_a: assert property (!busy && cmd_write &&
        taskfile.cmd != 8'h3B |=> !busy)
        else $error("foreign command code started work");
    end_walk_a: assert property ($fell(busy) |-> s_finish)
        else $error("finish without single done pulse");
    err_mask_a: assert property (done_pulse |->
        (error_report & 8'h6A) == 8'h00)
        else $error("unreported error bit set");
    se_err_a: assert property (done_pulse && ending_status[5] |->
        !ending_status[0])
        else $error("stream error with error bit");
    sreq_busy_a: assert property (sector_req |-> busy)
        else $error("sector request while idle");
    bsy_flag_a: assert property (ending_status[7] == busy)
        else $error("busy flag disagrees with busy");
    hold_report_a: assert property (!busy && !$past(busy) |->
        $stable(error_report) && $stable(ending_status))
        else $error("report changed while idle");
endmodule
bind swc_core swc_core_props props_u (.mclk(mclk), .rstn(rstn),
    .cmd_write(cmd_write), .taskfile(taskfile), .sector_req(sector_req),
    .busy(busy), .done_pulse(done_pulse), .error_report(error_report),
    .ending_status(ending_status));

// file: tb/swc_media_model.sv
// behavioural media engine answering sector and flush requests
`timescale 1ns/1ps
module swc_media_model
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sector_req,
    input wire logic flush_req,
    input wire logic [7:0] gap,
    input wire logic [16:0] err_a,
    input wire logic [16:0] err_b,
    output logic sector_done,
    output logic xfer_error,
    output logic crc_error,
    output logic [47:0] sector_lba,
    output logic flush_done,
    output logic [16:0] n
);
    // ********
    // media side
    // ********
    logic [7:0] w;
    logic [47:0] lba;
    // one answer every gap+1 cycles; n counts sectors the core took
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
        begin
            w <= 8'h00;
            n <= 17'h0_0000;
            sector_done <= 1'b0;
            flush_done <= 1'b0;
        end
        else
        begin
            sector_done <= sector_req && w == gap;
            flush_done <= flush_req && !sector_req && w == gap;
            w <= (w == gap || !(sector_req || flush_req)) ? 8'h00 : w + 8'h01;
            if (sector_req && sector_done)
                n <= n + 17'h0_0001;
        end
    // address is only valid with done; otherwise show its inverse
    assign lba = 48'h0A0B_0C0D_0E0F + {31'h0000_0000, n};
    assign sector_lba = sector_done ? lba : ~lba;
    assign xfer_error = sector_done && n + 17'h0_0001 == err_a;
    assign crc_error = sector_done && n + 17'h0_0001 == err_b;
endmodule

// file: tb/tb.sv
// self-checking bench for the stream write command core
`timescale 1ns/1ps
module tb
    import swc_pkg::*;
;
    // ********
    // bench
    // ********
    localparam logic [47:0] LBA0 = 48'h0A0B_0C0D_0E0F;
    logic mclk, rstn, cmd_write, hob, sector_done, xfer_error, crc_error;
    logic flush_done, sector_req, flush_req, urgent_request, busy;
    logic resume_error_recovery, done_pulse;
    swc_taskfile_type taskfile;
    logic [15:0] time_unit_us;
    logic [7:0] default_limit, gap, error_report, ending_status;
    logic [7:0] lba_sector_number, lba_cyl_low, lba_cyl_high;
    logic [47:0] sector_lba;
    logic [16:0] err_a, err_b, n, n0;
    logic [2:0] stream_id;
    int err_count = 0;
    int checks_done = 0;
    int cyc;
    swc_core dut_u (.mclk(mclk), .rstn(rstn), .cmd_write(cmd_write),
        .taskfile(taskfile), .time_unit_us(time_unit_us),
        .default_limit(default_limit), .hob(hob), .sector_done(sector_done),
        .xfer_error(xfer_error), .crc_error(crc_error),
        .sector_lba(sector_lba), .flush_done(flush_done),
        .sector_req(sector_req), .flush_req(flush_req), .stream_id(stream_id),
        .urgent_request(urgent_request),
        .resume_error_recovery(resume_error_recovery), .busy(busy),
        .done_pulse(done_pulse), .error_report(error_report),
        .ending_status(ending_status), .lba_sector_number(lba_sector_number),
        .lba_cyl_low(lba_cyl_low), .lba_cyl_high(lba_cyl_high));
    swc_media_model media_u (.mclk(mclk), .rstn(rstn),
        .sector_req(sector_req), .flush_req(flush_req), .gap(gap),
        .err_a(err_a), .err_b(err_b), .sector_done(sector_done),
        .xfer_error(xfer_error), .crc_error(crc_error),
        .sector_lba(sector_lba), .flush_done(flush_done), .n(n));
    // free running 200 MHz clock
    always #2.5 mclk = ~mclk;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // cmd_write held two cycles: the second lands while busy
    task automatic run(input logic [7:0] fc, input logic [7:0] fp,
                       input logic [15:0] cnt);
        @(posedge mclk);
        n0 = n;
        taskfile <= '{fc, fp, cnt[7:0], cnt[15:8], 8'h3B};
        cmd_write <= 1'b1;
        repeat (2) @(posedge mclk);
        cmd_write <= 1'b0;
        cyc = 0;
        while (done_pulse !== 1'b1 && cyc < 70000)
        begin
            @(posedge mclk);
            #1;
            cyc++;
        end
        // a command that never ends counts against the run
        if (cyc >= 70000)
        begin
            err_count++;
            $display("ERROR %0t: command never completed", $time);
        end
    endtask
    task automatic read_lba(input logic [47:0] e);
        @(posedge mclk);
        hob <= 1'b0;
        @(posedge mclk);
        #1;
        chk({lba_cyl_high, lba_cyl_low, lba_sector_number}, e[23:0]);
        @(posedge mclk);
        hob <= 1'b1;
        @(posedge mclk);
        #1;
        chk({lba_cyl_high, lba_cyl_low, lba_sector_number}, e[47:24]);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard sized above the longest expected run
    initial
    begin
        repeat (95000) @(posedge mclk);
        err_count++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        cmd_write = 1'b0;
        taskfile = '0;
        time_unit_us = 16'h0004;
        default_limit = 8'h00;
        hob = 1'b0;
        gap = 8'h01;
        err_a = '0;
        err_b = '0;
        repeat (16) @(posedge mclk);
        chk({busy, ending_status}, 9'h040);
        rstn <= 1'b1;
        @(posedge mclk);
        taskfile <= '{8'h00, 8'h00, 8'h01, 8'h00, 8'h35};
        cmd_write <= 1'b1;
        @(posedge mclk);
        cmd_write <= 1'b0;
        @(posedge mclk);
        #1;
        chk(busy, 1'b0);
        run(8'h00, 8'h00, 16'h0102);
        chk(n - n0, 17'd258);
        chk({ending_status, error_report}, 16'h4000);
        gap <= 8'h00;
        run(8'h00, 8'h00, 16'h0000);
        chk(n - n0, 17'd65536);
        err_a <= n + 17'd5;
        run(8'h00, 8'h00, 16'h000A);
        chk(n - n0, 17'd5);
        chk({ending_status, error_report}, 16'h4114);
        read_lba(LBA0 + n0 + 48'd4);
        err_a <= n + 17'd2;
        err_b <= n + 17'd4;
        run(8'h40, 8'h00, 16'h0006);
        chk(n - n0, 17'd6);
        chk({ending_status, error_report}, 16'h6090);
        read_lba(LBA0 + n0 + 48'd1);
        err_a <= '0;
        err_b <= '0;
        gap <= 8'h63;
        default_limit <= 8'h01;
        run(8'hC0, 8'h00, 16'h0064);
        chk({ending_status, error_report}, 16'h6001);
        chk(cyc > 3000 && cyc < 3400, 1'b1);
        chk(n - n0 < 17'd100, 1'b1);
        chk(urgent_request, 1'b1);
        gap <= 8'h1E;
        run(8'hB5, 8'h00, 16'h0002);
        chk(cyc > 85, 1'b1);
        chk({stream_id, resume_error_recovery}, 4'hB);
        chk({ending_status, error_report}, 16'h4000);
        end_of_test();
    end
endmodule
